// ===== include/epi_pkg.sv
// constants, types and helpers shared by the external pin interrupt unit
`default_nettype none
package epi_pkg;
    // register word indices; byte address is four times the index
    localparam logic [7:0] IDX_CHANGE_FLAGS = 8'h1b;
    localparam logic [7:0] IDX_EXT_FLAGS = 8'h1c;
    localparam logic [7:0] IDX_EXT_MASK = 8'h1d;
    localparam logic [7:0] IDX_CHANGE_CTRL = 8'h68;
    localparam logic [7:0] IDX_SENSE_CTRL = 8'h69;
    localparam logic [7:0] IDX_PIN_MASK_A = 8'h6b;
    localparam logic [7:0] IDX_PIN_MASK_B = 8'h6c;
    localparam logic [7:0] IDX_PIN_MASK_C = 8'h6d;

    // field positions
    localparam int SENSE_A_LSB = 0;
    localparam int SENSE_B_LSB = 2;
    localparam int SRC_A = 0;
    localparam int SRC_B = 1;
    localparam int SRC_C = 2;

    // field widths
    localparam int SENSE_W = 4;
    localparam int EXT_W = 2;
    localparam int GROUP_W = 3;
    localparam int MASK_A_W = 8;
    localparam int MASK_B_W = 7;
    localparam int MASK_C_W = 8;
    localparam int CHANGE_W = 24;

    // reset values
    localparam logic [3:0] RST_SENSE = 4'h0;
    localparam logic [1:0] RST_EXT_MASK = 2'h0;
    localparam logic [1:0] RST_EXT_FLAGS = 2'h0;
    localparam logic [2:0] RST_GROUP_CTRL = 3'h0;
    localparam logic [2:0] RST_GROUP_FLAGS = 3'h0;
    localparam logic [7:0] RST_PIN_MASK = 8'h00;

    // cycles after reset release before pin history is trusted
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    typedef enum logic [1:0] {
        SENSE_LOW,
        SENSE_ANY,
        SENSE_FALL,
        SENSE_RISE
    } epi_sense_type;

    typedef struct packed {
        logic groupC;
        logic groupB;
        logic groupA;
        logic extB;
        logic extA;
    } epi_src_type;

    function automatic logic senseHit(epi_sense_type mode, logic cur, logic prev);
        case (mode)
            SENSE_ANY: senseHit = cur ^ prev;
            SENSE_FALL: senseHit = prev & ~cur;
            SENSE_RISE: senseHit = cur & ~prev;
            default: senseHit = 1'b0;
        endcase
    endfunction
endpackage
`default_nettype wire

// ===== logic/epi_external_pin_interrupt_unit.sv
// external pin interrupt unit: dedicated inputs, pin-change groups, register slave
// Functional notes
// - pins interrupt even when driven as outputs; direction is not looked at.
// - group C request on any masked toggle of change inputs 23 to 16.
// - group B request on any masked toggle of change inputs 14 to 8.
// - group A request on any masked toggle of change inputs 7 to 0.
// - pin-change detection does not depend on the io clock; wakes from sleep.
// - level mode keeps requesting while the dedicated pin stays low.
// - edge detection on dedicated pins only while the io clock runs.
// - low level on dedicated pins seen without io clock, drives wake-up.
// - level gone before start-up ends: wake happens, no interrupt.
// - sense bits 3..2 pick mode of input B: low, any, fall, rise.
// - sense bits 1..0 pick mode of input A with the same encoding.
// - dedicated pins sampled before edge detect; pulses over one clock caught.
// - dedicated request needs its mask bit and the global enable.
// - each of the five sources has its own request line.
// - edge or change sets dedicated flag; cleared by vector entry or write one.
// - dedicated flag held cleared while its input is in level mode.
// - unused register bits read as zero.
// - group enables at bits 2 and 1 gate with the global enable.
// - three per-pin mask registers choose contributing change inputs.
// - group A enabled by control bit 0 with the global enable.
// - each group has a flag set on change, cleared by vector or write one.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module epi_external_pin_interrupt_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic dedicatedIrqPinA,
    input wire logic dedicatedIrqPinB,
    input wire logic [23:0] changeInputs,
    input wire logic globalIrqEnable,
    input wire logic ioClockRun,
    input wire epi_pkg::epi_src_type vectorTaken,
    output epi_pkg::epi_src_type irqRequest,
    output logic wakeRequest
);
    logic [1:0] rstPipe;
    logic rstB;
    logic busAck;
    logic wrTake;
    logic rdTake;
    logic [31:0] next_readdata;
    logic [3:0] senseCtrl;
    logic [1:0] extMask;
    logic [1:0] extFlags;
    logic [2:0] groupCtrl;
    logic [2:0] changeFlags;
    logic [7:0] pinMaskA;
    logic [6:0] pinMaskB;
    logic [7:0] pinMaskC;
    logic [25:0] pinSync;
    logic [23:0] changeSync;
    logic [23:0] changePrev;
    logic [23:0] changeDelta;
    logic [1:0] settleCnt;
    logic settled;
    logic [2:0] groupHit;
    logic [1:0] extTrig;
    logic [1:0] extLow;
    logic [1:0] extLevelMode;
    logic [1:0] extClear;
    logic [2:0] groupClear;
    epi_pkg::epi_sense_type modeA;
    epi_pkg::epi_sense_type modeB;
    logic [1:0] levelWake;
    logic [2:0] changeWake;

    // reset is released through two flops; the first feeds only the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rstPipe <= 2'b00;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstB = rstPipe[1];

    // bus slave: every access waits exactly one cycle, then completes
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            busAck <= 1'b0;
        end else begin
            busAck <= (read | write) & ~busAck;
        end
    end
    assign waitrequest = (read | write) & ~busAck;
    assign wrTake = write & busAck & byteenable[0];
    assign rdTake = read & ~busAck;

    // read mux; bits that hold no field and unmapped words read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (address)
            epi_pkg::IDX_SENSE_CTRL: next_readdata[3:0] = senseCtrl;
            epi_pkg::IDX_EXT_MASK: next_readdata[1:0] = extMask;
            epi_pkg::IDX_EXT_FLAGS: next_readdata[1:0] = extFlags;
            epi_pkg::IDX_CHANGE_CTRL: next_readdata[2:0] = groupCtrl;
            epi_pkg::IDX_CHANGE_FLAGS: next_readdata[2:0] = changeFlags;
            epi_pkg::IDX_PIN_MASK_A: next_readdata[7:0] = pinMaskA;
            epi_pkg::IDX_PIN_MASK_B: next_readdata[6:0] = pinMaskB;
            epi_pkg::IDX_PIN_MASK_C: next_readdata[7:0] = pinMaskC;
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    // read data is captured one edge early so it stands when waitrequest drops
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            readdata <= 32'h0000_0000;
        end else if (rdTake) begin
            readdata <= next_readdata;
        end
    end

    // control registers written by software
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            senseCtrl <= epi_pkg::RST_SENSE;
            extMask <= epi_pkg::RST_EXT_MASK;
            groupCtrl <= epi_pkg::RST_GROUP_CTRL;
        end else if (wrTake) begin
            case (address)
                epi_pkg::IDX_SENSE_CTRL: senseCtrl <= writedata[3:0];
                epi_pkg::IDX_EXT_MASK: extMask <= writedata[1:0];
                epi_pkg::IDX_CHANGE_CTRL: groupCtrl <= writedata[2:0];
                default: ;
            endcase
        end
    end

    // per-pin masks; the top bit of mask B does not exist
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            pinMaskA <= epi_pkg::RST_PIN_MASK;
            pinMaskB <= epi_pkg::RST_PIN_MASK[6:0];
            pinMaskC <= epi_pkg::RST_PIN_MASK;
        end else if (wrTake) begin
            case (address)
                epi_pkg::IDX_PIN_MASK_A: pinMaskA <= writedata[7:0];
                epi_pkg::IDX_PIN_MASK_B: pinMaskB <= writedata[6:0];
                epi_pkg::IDX_PIN_MASK_C: pinMaskC <= writedata[7:0];
                default: ;
            endcase
        end
    end

    // pins are read as inputs whatever their port direction
    epi_sync #(
        .WIDTH(26)
    ) u_pinSync (
        .clk(clk),
        .rstB(rstB),
        .d({dedicatedIrqPinB, dedicatedIrqPinA, changeInputs}),
        .q(pinSync)
    );
    assign changeSync = pinSync[23:0];

    // the synchroniser starts from zero; ignore its first fill after reset
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            settleCnt <= 2'h0;
        end else if (!settled) begin
            settleCnt <= settleCnt + 2'h1;
        end
    end
    assign settled = (settleCnt == epi_pkg::SETTLE_CYCLES);

    // change history is not gated by the io clock run signal
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            changePrev <= 24'h00_0000;
        end else begin
            changePrev <= changeSync;
        end
    end
    assign changeDelta = settled ? (changeSync ^ changePrev) : 24'h00_0000;

    assign groupHit[epi_pkg::SRC_A] = |(changeDelta[7:0] & pinMaskA);
    assign groupHit[epi_pkg::SRC_B] = |(changeDelta[14:8] & pinMaskB);
    assign groupHit[epi_pkg::SRC_C] = |(changeDelta[23:16] & pinMaskC);

    assign modeA = epi_pkg::epi_sense_type'(senseCtrl[epi_pkg::SENSE_A_LSB +: 2]);
    assign modeB = epi_pkg::epi_sense_type'(senseCtrl[epi_pkg::SENSE_B_LSB +: 2]);

    epi_sense u_senseA (
        .clk(clk),
        .rstB(rstB),
        .pinSync(pinSync[24]),
        .mode(modeA),
        .ioRun(ioClockRun),
        .settled(settled),
        .trigger(extTrig[epi_pkg::SRC_A]),
        .lowActive(extLow[epi_pkg::SRC_A])
    );

    epi_sense u_senseB (
        .clk(clk),
        .rstB(rstB),
        .pinSync(pinSync[25]),
        .mode(modeB),
        .ioRun(ioClockRun),
        .settled(settled),
        .trigger(extTrig[epi_pkg::SRC_B]),
        .lowActive(extLow[epi_pkg::SRC_B])
    );

    assign extLevelMode[epi_pkg::SRC_A] = (modeA == epi_pkg::SENSE_LOW);
    assign extLevelMode[epi_pkg::SRC_B] = (modeB == epi_pkg::SENSE_LOW);

    // write one to clear, or vector entry clears
    always_comb begin
        extClear = {vectorTaken.extB, vectorTaken.extA};
        groupClear = {vectorTaken.groupC, vectorTaken.groupB, vectorTaken.groupA};
        if (wrTake && address == epi_pkg::IDX_EXT_FLAGS) begin
            extClear = extClear | writedata[1:0];
        end
        if (wrTake && address == epi_pkg::IDX_CHANGE_FLAGS) begin
            groupClear = groupClear | writedata[2:0];
        end
    end

    // dedicated flags: a trigger wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            extFlags <= epi_pkg::RST_EXT_FLAGS;
        end else begin
            for (int i = 0; i < epi_pkg::EXT_W; i++) begin
                if (extLevelMode[i]) begin
                    extFlags[i] <= 1'b0;
                end else if (extTrig[i]) begin
                    extFlags[i] <= 1'b1;
                end else if (extClear[i]) begin
                    extFlags[i] <= 1'b0;
                end
            end
        end
    end

    // group flags set on a masked change regardless of the group enable
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            changeFlags <= epi_pkg::RST_GROUP_FLAGS;
        end else begin
            for (int i = 0; i < epi_pkg::GROUP_W; i++) begin
                if (groupHit[i]) begin
                    changeFlags[i] <= 1'b1;
                end else if (groupClear[i]) begin
                    changeFlags[i] <= 1'b0;
                end
            end
        end
    end

    // level requests follow the pin itself, so a level gone early leaves nothing
    assign irqRequest.extA = globalIrqEnable & extMask[epi_pkg::SRC_A]
        & (extLevelMode[epi_pkg::SRC_A] ? extLow[epi_pkg::SRC_A]
                                        : extFlags[epi_pkg::SRC_A]);
    assign irqRequest.extB = globalIrqEnable & extMask[epi_pkg::SRC_B]
        & (extLevelMode[epi_pkg::SRC_B] ? extLow[epi_pkg::SRC_B]
                                        : extFlags[epi_pkg::SRC_B]);
    assign irqRequest.groupA = globalIrqEnable & groupCtrl[epi_pkg::SRC_A]
        & changeFlags[epi_pkg::SRC_A];
    assign irqRequest.groupB = globalIrqEnable & groupCtrl[epi_pkg::SRC_B]
        & changeFlags[epi_pkg::SRC_B];
    assign irqRequest.groupC = globalIrqEnable & groupCtrl[epi_pkg::SRC_C]
        & changeFlags[epi_pkg::SRC_C];

    // wake path uses the raw pins so it works with the io clock stopped
    assign levelWake[0] = extMask[0] & extLevelMode[0] & ~dedicatedIrqPinA;
    assign levelWake[1] = extMask[1] & extLevelMode[1] & ~dedicatedIrqPinB;
    assign changeWake[0] = groupCtrl[0] & |((changeInputs[7:0] ^ changeSync[7:0]) & pinMaskA);
    assign changeWake[1] = groupCtrl[1]
        & |((changeInputs[14:8] ^ changeSync[14:8]) & pinMaskB);
    assign changeWake[2] = groupCtrl[2]
        & |((changeInputs[23:16] ^ changeSync[23:16]) & pinMaskC);
    // limitation: a change wake lasts only until the synchroniser catches up
    assign wakeRequest = settled & (|levelWake | |changeWake);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstB);

    property p_level_request;
        (extLevelMode[0] && extMask[0] && globalIrqEnable && !pinSync[24]) |-> irqRequest.extA;
    endproperty
    a_level_request: assert property (p_level_request)
        else $error("level request missing while pin low");

    property p_level_flag_clear;
        extLevelMode[1] |=> !extFlags[1];
    endproperty
    a_level_flag_clear: assert property (p_level_flag_clear)
        else $error("dedicated flag set in level mode");

    property p_write_one_clears;
        (wrTake && address == epi_pkg::IDX_EXT_FLAGS && writedata[0] && !extTrig[0])
            |=> !extFlags[0];
    endproperty
    a_write_one_clears: assert property (p_write_one_clears)
        else $error("write one did not clear dedicated flag");

    property p_ack_clears_group;
        (vectorTaken.groupB && !groupHit[1]) |=> !changeFlags[1];
    endproperty
    a_ack_clears_group: assert property (p_ack_clears_group)
        else $error("vector taken did not clear group flag");

    property p_group_a_sets;
        $rose(changeSync[3]) && pinMaskA[3] && settled |=> changeFlags[0];
    endproperty
    a_group_a_sets: assert property (p_group_a_sets)
        else $error("masked change in group A lost");

    property p_group_c_from_pin;
        (settled && pinMaskC[7] && $changed(changeInputs[23]) && !wrTake && vectorTaken == '0)
            |-> ##3 changeFlags[2];
    endproperty
    a_group_c_from_pin: assert property (p_group_c_from_pin)
        else $error("pin toggle in group C not flagged after sync");

    property p_group_gate;
        irqRequest.groupC |-> (globalIrqEnable && groupCtrl[2] && changeFlags[2]);
    endproperty
    a_group_gate: assert property (p_group_gate)
        else $error("group C request without enables");

    property p_ded_gate;
        irqRequest.extB |-> (globalIrqEnable && extMask[1]);
    endproperty
    a_ded_gate: assert property (p_ded_gate)
        else $error("dedicated request without mask and global enable");

    property p_reserved_zero;
        (read && !waitrequest && address == epi_pkg::IDX_EXT_MASK) |-> readdata[31:2] == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved mask bits read nonzero");

    property p_level_wake;
        (settled && extMask[0] && extLevelMode[0] && !dedicatedIrqPinA) |-> wakeRequest;
    endproperty
    a_level_wake: assert property (p_level_wake)
        else $error("low level on dedicated pin gave no wake request");

    property p_b_group_excl;
        (settled && $changed(changeSync[15]) && !(|(changeDelta[14:8] & pinMaskB))
            && !changeFlags[1] && !vectorTaken.groupB) |=> !changeFlags[1];
    endproperty
    a_b_group_excl: assert property (p_b_group_excl)
        else $error("input 15 raised group B flag");
endmodule
`default_nettype wire

// ===== logic/epi_sense.sv
// sense logic for one dedicated interrupt input
`timescale 1ns/1ns
`default_nettype none
module epi_sense (
    input wire logic clk,
    input wire logic rstB,
    input wire logic pinSync,
    input wire epi_pkg::epi_sense_type mode,
    input wire logic ioRun,
    input wire logic settled,
    output logic trigger,
    output logic lowActive
);
    logic pinPrev;

    // history follows the pin always, so a pin moved during sleep gives no late edge
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            pinPrev <= 1'b0;
        end else begin
            pinPrev <= pinSync;
        end
    end

    // edges only count while the io clock runs
    assign trigger = ioRun & settled & epi_pkg::senseHit(mode, pinSync, pinPrev);
    // low level is seen regardless of the io clock
    assign lowActive = (mode == epi_pkg::SENSE_LOW) & ~pinSync;

    property p_no_edge_asleep;
        @(posedge clk) disable iff (!rstB) !ioRun |-> !trigger;
    endproperty
    a_no_edge_asleep: assert property (p_no_edge_asleep)
        else $error("edge recognised while io clock stopped");

    property p_fall_seen;
        @(posedge clk) disable iff (!rstB)
            (ioRun && settled && mode == epi_pkg::SENSE_FALL && $fell(pinSync)) |-> trigger;
    endproperty
    a_fall_seen: assert property (p_fall_seen)
        else $error("falling edge missed");
endmodule
`default_nettype wire

// ===== logic/epi_sync.sv
// two-stage synchroniser for a bundle of level inputs
`timescale 1ns/1ns
`default_nettype none
module epi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rstB,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second flop, to keep metastability contained
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            stage1 <= '0;
            q <= '0;
        end else begin
            stage1 <= d;
            q <= stage1;
        end
    end
endmodule
`default_nettype wire

// ===== test/epi_core_model.sv
// core dispatch model: takes pending requests and answers with vector pulses
`timescale 1ns/1ns
`default_nettype none
module epi_core_model (
    input wire logic clk,
    input wire logic rstB,
    input wire logic ackOn,
    input wire epi_pkg::epi_src_type irqRequest,
    output epi_pkg::epi_src_type vectorTaken
);
    // each source owns its vector; no pulse twice in a row so a flag gets one clear
    always_ff @(posedge clk or negedge rstB) begin
        if (!rstB) begin
            vectorTaken <= '0;
        end else begin
            vectorTaken <= ackOn ? epi_pkg::epi_src_type'(irqRequest & ~vectorTaken) : '0;
        end
    end
endmodule
`default_nettype wire

// ===== test/epi_external_pin_interrupt_unit_bench.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/1ns
`default_nettype none
module epi_external_pin_interrupt_unit_bench;
    logic clk, rst_b, read, write, gie, ioRun, ackOn, waitrequest, wakeRequest;
    logic [7:0] address;
    logic [31:0] writedata, readdata;
    logic [1:0] pins;
    logic [23:0] chg;
    epi_pkg::epi_src_type vt, req;
    int n_fail, checks_done;

    epi_external_pin_interrupt_unit epi_external_pin_interrupt_unit_inst (
        .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
        .byteenable(4'h1), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .dedicatedIrqPinA(pins[0]), .dedicatedIrqPinB(pins[1]),
        .changeInputs(chg), .globalIrqEnable(gie), .ioClockRun(ioRun),
        .vectorTaken(vt), .irqRequest(req), .wakeRequest(wakeRequest)
    );
    epi_core_model epi_core_model_inst (
        .clk(clk), .rstB(rst_b), .ackOn(ackOn), .irqRequest(req), .vectorTaken(vt)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task close_out;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // the request stands until the edge that sees waitrequest low; data is taken there
    task bus(input logic wr, input logic [7:0] idx, input logic [7:0] val,
             output logic [31:0] got);
        int n;
        @(posedge clk);
        address <= idx;
        writedata <= {24'h0, val};
        write <= wr;
        read <= ~wr;
        n = 0;
        @(posedge clk);
        while (waitrequest !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) begin
            n_fail++;
            close_out();
        end
        got = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task wr(input logic [7:0] idx, input logic [7:0] val);
        logic [31:0] d;
        bus(1'b1, idx, val, d);
    endtask

    task rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, d);
        chk($sformatf("register %h", idx), {24'h0, exp}, d);
    endtask

    // pin seen at edge k shows as a flag at edge k+3
    task settle;
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask

    task t_regs;
        logic [7:0] idx [9];
        logic [7:0] exp [9];
        idx = '{epi_pkg::IDX_CHANGE_FLAGS, epi_pkg::IDX_EXT_FLAGS, epi_pkg::IDX_EXT_MASK,
                epi_pkg::IDX_CHANGE_CTRL, epi_pkg::IDX_SENSE_CTRL, epi_pkg::IDX_PIN_MASK_A,
                epi_pkg::IDX_PIN_MASK_B, epi_pkg::IDX_PIN_MASK_C, 8'h10};
        exp = '{8'h00, 8'h00, 8'h03, 8'h07, 8'h0f, 8'hff, 8'h7f, 8'hff, 8'h00};
        for (int i = 0; i < 9; i++) begin
            rd(idx[i], 8'h00);
            wr(idx[i], 8'hff);
            rd(idx[i], exp[i]);
        end
    endtask

    task t_groups;
        gie <= 1'b1;
        for (int g = 0; g < 3; g++) begin
            chg <= chg ^ (24'h1 << (g * 8 + 3));
            settle();
            chk("group request", 32'h1 << (2 + g), {27'h0, req});
            rd(epi_pkg::IDX_CHANGE_FLAGS, 8'h1 << g);
            wr(epi_pkg::IDX_CHANGE_FLAGS, 8'h1 << g);
            rd(epi_pkg::IDX_CHANGE_FLAGS, 8'h00);
        end
        chg <= chg ^ 24'h008000;
        settle();
        rd(epi_pkg::IDX_CHANGE_FLAGS, 8'h00);
        wr(epi_pkg::IDX_PIN_MASK_A, 8'hfe);
        chg <= chg ^ 24'h000001;
        settle();
        rd(epi_pkg::IDX_CHANGE_FLAGS, 8'h00);
        gie <= 1'b0;
        chg <= chg ^ 24'h800000;
        settle();
        chk("request without global enable", 32'h0, {27'h0, req});
        rd(epi_pkg::IDX_CHANGE_FLAGS, 8'h04);
        wr(epi_pkg::IDX_CHANGE_FLAGS, 8'h07);
        gie <= 1'b1;
    endtask

    task t_edges;
        for (int s = 0; s < 2; s++) begin
            for (int m = 1; m < 4; m++) begin
                wr(epi_pkg::IDX_SENSE_CTRL, 8'(m << (2 * s)));
                pins[s] <= 1'b0;
                settle();
                chk("edge request", (m != 3) ? 32'h1 << s : 32'h0, {27'h0, req});
                rd(epi_pkg::IDX_EXT_FLAGS, (m != 3) ? 8'h1 << s : 8'h0);
                wr(epi_pkg::IDX_EXT_FLAGS, 8'h03);
                pins[s] <= 1'b1;
                settle();
                rd(epi_pkg::IDX_EXT_FLAGS, (m != 2) ? 8'h1 << s : 8'h0);
                wr(epi_pkg::IDX_EXT_FLAGS, 8'h03);
            end
        end
        // edges during deep sleep are dropped, not queued
        wr(epi_pkg::IDX_SENSE_CTRL, 8'h02);
        ioRun <= 1'b0;
        pins[0] <= 1'b0;
        settle();
        @(posedge clk);
        pins[0] <= 1'b1;
        settle();
        @(posedge clk);
        ioRun <= 1'b1;
        rd(epi_pkg::IDX_EXT_FLAGS, 8'h00);
        wr(epi_pkg::IDX_SENSE_CTRL, 8'h00);
        ioRun <= 1'b0;
        pins[0] <= 1'b0;
        settle();
        chk("wake", 32'h1, {31'h0, wakeRequest});
        @(posedge clk);
        ioRun <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
        chk("level request", 32'h1, {27'h0, req});
        rd(epi_pkg::IDX_EXT_FLAGS, 8'h00);
        gie <= 1'b0;
        settle();
        chk("level without global enable", 32'h0, {27'h0, req});
        @(posedge clk);
        gie <= 1'b1;
        pins[0] <= 1'b1;
        settle();
        chk("level released", 32'h0, {27'h0, req});
        chk("wake released", 32'h0, {31'h0, wakeRequest});
    endtask

    task t_vector;
        wr(epi_pkg::IDX_SENSE_CTRL, 8'h04);
        pins[1] <= 1'b0;
        chg <= chg ^ 24'h000202;
        settle();
        chk("pending", 32'he, {27'h0, req});
        @(posedge clk);
        ackOn <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("after vector", 32'h0, {27'h0, req});
        @(posedge clk);
        ackOn <= 1'b0;
        rd(epi_pkg::IDX_EXT_FLAGS, 8'h00);
        rd(epi_pkg::IDX_CHANGE_FLAGS, 8'h00);
    endtask

    initial begin
        n_fail = 0;
        checks_done = 0;
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 8'h00;
        writedata = 32'h0;
        gie = 1'b0;
        ioRun = 1'b1;
        ackOn = 1'b0;
        pins = 2'b11;
        chg = 24'h0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        t_regs();
        t_groups();
        t_edges();
        t_vector();
        close_out();
    end
endmodule
`default_nettype wire
